// file: verilog/fbc_pkg.sv
// Package of constants and types for the parallel flash bus controller.
package fbc_pkg;
  // Timing in ns; cycle counts at 200 MHz (5 ns)
  localparam int CLK_PERIOD_NS = 5;
  localparam int SELECT_ACCESS_TIME_NS = 70;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_HIGH_NS = 30;
  localparam int RESET_PULSE_WIDTH_NS = 500;
  localparam int RESET_RECOVERY_TIME_NS = 20000;
  localparam int SELECT_ACCESS_CYC = (SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVERY_CYC = (RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // Host operations
  typedef enum logic [1:0] {
    FBC_OP_READ,
    FBC_OP_WRITE,
    FBC_OP_RESET
  } fbc_op_t;

  // Request as presented at the user side
  typedef struct packed {
    fbc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic low_byte;
    logic [DATA_W-1:0] wdata;
  } fbc_req_t;

  // Flash strobe bundle: select, output gate, write strobe and reset, all active low
  typedef struct packed {
    logic flash_select_n;
    logic output_gate_n;
    logic write_strobe_n;
    logic reset_n;
  } fbc_strobe_t;

  // Clamp a cycle count to at least one
  function automatic logic [CNT_W-1:0] fbc_cyc(input int cyc);
    fbc_cyc = (cyc < 1) ? CNT_W'(1) : CNT_W'(cyc);
  endfunction
endpackage

// file: verilog/fbc_sync.sv
// Two-flop synchroniser bank for pins arriving from the flash.
module fbc_sync import fbc_pkg::*; #(
  parameter int W = 1
) (
  input wire logic sys_clk_i, // System clock
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic [W-1:0] d_i, // Asynchronous input
  output logic [W-1:0] q_o // Synchronised output
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule

// file: verilog/fbc_ctrl.sv
// Host-side controller driving a parallel flash die through its pins.
module fbc_ctrl import fbc_pkg::*; #(
  parameter int RESET_RECOVERY_CYCLES = RESET_RECOVERY_CYC
) (
  input wire logic sys_clk_i, // System clock, 200 MHz
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic req_valid_i, // User request valid
  output logic req_ready_o, // Controller idle, request taken
  input wire fbc_req_t req_i, // User request
  input wire logic word_mode_i, // 1 = word, 0 = byte configuration
  input wire logic boost_program_i, // Request high voltage on protect pin
  output logic rsp_valid_o, // Read data valid pulse
  output logic [DATA_W-1:0] rsp_data_o, // Read data
  output logic busy_o, // Flash reports busy (synchronised)
  output logic [ADDR_W-1:0] flash_addr_o, // Flash address
  output logic flash_select_n_o, // Chip select, active low
  output logic output_gate_n_o, // Output enable, active low
  output logic write_strobe_n_o, // Write enable, active low
  output logic flash_reset_n_o, // Hardware reset, active low
  output logic width_select_n_o, // High = word configuration
  output logic protect_boost_hv_o, // Drive high voltage level on protect pin
  output logic protect_boost_o, // Logic level on protect pin when not boosted
  input wire logic [DATA_W-1:0] dq_i, // Data pins in
  output logic [DATA_W-1:0] dq_o, // Data pins out
  output logic [DATA_W-1:0] dq_oe_o, // Data pin enables, high = driving
  input wire logic ready_busy_n_i // Device ready (1) or busy (0)
);
  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  logic [DATA_W:0] sync_q;
  fbc_sync #(.W(DATA_W + 1)) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({ready_busy_n_i, dq_i}),
    .q_o(sync_q)
  );
  logic ready_s;
  logic [DATA_W-1:0] dq_s;
  assign ready_s = sync_q[DATA_W];
  assign dq_s = sync_q[DATA_W-1:0];

  // ************************************************************
  // Sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    FBC_IDLE,
    FBC_RD,
    FBC_WR_LOW,
    FBC_WR_HIGH,
    FBC_RST_LOW,
    FBC_RST_WAIT
  } fbc_state_t;

  // Two synchroniser stages plus one cycle of setup margin add to the read sample point,
  // otherwise the first flop samples the bus in the very instant the data turns valid
  localparam logic [CNT_W-1:0] RD_CYC = fbc_cyc(SELECT_ACCESS_CYC + 3);
  localparam logic [CNT_W-1:0] WL_CYC = fbc_cyc(WRITE_PULSE_CYC);
  localparam logic [CNT_W-1:0] WH_CYC = fbc_cyc(WRITE_HIGH_CYC);
  localparam logic [CNT_W-1:0] RP_CYC = fbc_cyc(RESET_PULSE_CYC);
  localparam logic [CNT_W-1:0] RR_CYC = fbc_cyc(RESET_RECOVERY_CYCLES + 2);

  fbc_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  fbc_strobe_t stb, next_stb;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [DATA_W-1:0] oe, next_oe;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic word, next_word;
  logic hv, next_hv;

  // Ready returns only after reset recovery, so a reissued operation is accepted
  assign req_ready_o = (state == FBC_IDLE);

  always_comb begin
    next_state = state;
    next_cnt = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
    next_stb = stb;
    next_addr = addr;
    next_wdata = wdata;
    next_oe = oe;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_word = word;
    next_hv = hv;
    case (state)
      FBC_IDLE: begin
        // Width and boost only change between cycles so the device never sees them mid-access
        next_word = word_mode_i;
        next_hv = boost_program_i;
        next_stb = '{flash_select_n: 1'b1, output_gate_n: 1'b1, write_strobe_n: 1'b1, reset_n: 1'b1};
        next_oe = '0;
        if (req_valid_i) begin
          next_addr = req_i.addr;
          case (req_i.op)
            FBC_OP_READ: begin
              next_state = FBC_RD;
              next_cnt = RD_CYC;
              next_stb.flash_select_n = 1'b0;
              next_stb.output_gate_n = 1'b0;
              if (!word_mode_i) begin
                next_oe = 16'h8000;
                next_wdata = {req_i.low_byte, 15'h0000};
              end
            end
            FBC_OP_WRITE: begin
              // One request is one bus cycle; a bypass program is two requests
              next_state = FBC_WR_LOW;
              next_cnt = WL_CYC;
              next_stb.flash_select_n = 1'b0;
              next_stb.write_strobe_n = 1'b0;
              if (word_mode_i) begin
                next_oe = 16'hffff;
                next_wdata = req_i.wdata;
              end else begin
                next_oe = 16'h80ff;
                next_wdata = {req_i.low_byte, 7'h00, req_i.wdata[7:0]};
              end
            end
            FBC_OP_RESET: begin
              next_state = FBC_RST_LOW;
              next_cnt = RP_CYC;
              next_stb.reset_n = 1'b0;
            end
            default: next_state = FBC_IDLE;
          endcase
        end
      end
      FBC_RD: begin
        if (cnt == CNT_W'(1)) begin
          // Byte reads only carry lines 7..0, autoselect codes included
          next_rdata = word ? dq_s : {8'h00, dq_s[7:0]};
          next_rvalid = 1'b1;
          next_stb.flash_select_n = 1'b1;
          next_stb.output_gate_n = 1'b1;
          next_oe = '0;
          next_state = FBC_IDLE;
        end
      end
      FBC_WR_LOW: begin
        if (cnt == CNT_W'(1)) begin
          next_stb.write_strobe_n = 1'b1;
          next_stb.flash_select_n = 1'b1;
          next_cnt = WH_CYC;
          next_state = FBC_WR_HIGH;
        end
      end
      FBC_WR_HIGH: begin
        // Data held through the rising strobe, released after write-high time
        if (cnt == CNT_W'(1)) begin
          next_oe = '0;
          next_state = FBC_IDLE;
        end
      end
      FBC_RST_LOW: begin
        if (cnt == CNT_W'(1)) begin
          next_stb.reset_n = 1'b1;
          next_cnt = RR_CYC;
          next_state = FBC_RST_WAIT;
        end
      end
      FBC_RST_WAIT: begin
        // Bounded wait that also ends early once the busy line reads ready
        if (cnt == CNT_W'(1) || (cnt < RR_CYC - CNT_W'(2) && ready_s)) begin
          next_state = FBC_IDLE;
        end
      end
      default: next_state = FBC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= FBC_IDLE;
      cnt <= '0;
      stb <= '{flash_select_n: 1'b1, output_gate_n: 1'b1, write_strobe_n: 1'b1, reset_n: 1'b1};
      addr <= '0;
      wdata <= DATA_RST;
      oe <= '0;
      rdata <= DATA_RST;
      rvalid <= 1'b0;
      word <= 1'b1;
      hv <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      stb <= next_stb;
      addr <= next_addr;
      wdata <= next_wdata;
      oe <= next_oe;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      word <= next_word;
      hv <= next_hv;
    end
  end

  assign flash_addr_o = addr;
  assign flash_select_n_o = stb.flash_select_n;
  assign output_gate_n_o = stb.output_gate_n;
  assign write_strobe_n_o = stb.write_strobe_n;
  assign flash_reset_n_o = stb.reset_n;
  assign width_select_n_o = word;
  assign protect_boost_hv_o = hv;
  assign protect_boost_o = 1'b1;
  assign dq_o = wdata;
  assign dq_oe_o = oe;
  assign rsp_valid_o = rvalid;
  assign rsp_data_o = rdata;
  assign busy_o = ~ready_s;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_rd_start;
    state == FBC_IDLE && req_valid_i && req_i.op == FBC_OP_READ;
  endsequence

  // Output gate held low for the full select access time
  sequence s_gate_held;
    !output_gate_n_o [*8] ##1 !output_gate_n_o [*6];
  endsequence

  chk_read_strobes: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !output_gate_n_o |-> !flash_select_n_o && write_strobe_n_o)
    else $error("read strobes wrong");
  chk_write_strobes: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !write_strobe_n_o |-> !flash_select_n_o && output_gate_n_o)
    else $error("write strobes wrong");
  chk_gate_hiz: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !output_gate_n_o |-> (dq_oe_o & 16'h7fff) == 16'h0000)
    else $error("host drives data while gated");
  chk_byte_lanes: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !width_select_n_o |-> (dq_oe_o & 16'h7f00) == 16'h0000)
    else $error("byte mode drives upper lines");
  chk_read_time: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    s_rd_start |=> s_gate_held ##[1:4] rsp_valid_o)
    else $error("read returned too early or late");
  // Length of the current flash reset pulse, counted apart from the sequencer
  logic [CNT_W-1:0] rst_low_cnt, next_rst_low_cnt;

  always_comb begin
    next_rst_low_cnt = flash_reset_n_o ? '0 : rst_low_cnt + CNT_W'(1);
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_low_cnt <= '0;
    end else begin
      rst_low_cnt <= next_rst_low_cnt;
    end
  end

  chk_reset_pulse: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(flash_reset_n_o) |-> rst_low_cnt >= RP_CYC)
    else $error("reset pulse too short");
  chk_reset_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !flash_reset_n_o |-> flash_select_n_o && write_strobe_n_o && output_gate_n_o)
    else $error("access during reset");
  chk_boost_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $changed(protect_boost_hv_o) |-> $past(state) == FBC_IDLE)
    else $error("boost changed mid access");
endmodule

// file: test/fbc_flash_model.sv
// Behavioural model of the parallel flash die seen from its pins.
module fbc_flash_model import fbc_pkg::*; #(
  parameter int SEL_NS = 70, // Select access time
  parameter int PROG_NS = 200, // Program busy time
  parameter int REC_NS = 50 // Reset recovery time
) (
  input wire logic [ADDR_W-1:0] addr_i, // Address pins
  input wire logic sel_n_i, // Select, active low
  input wire logic gate_n_i, // Output gate, active low
  input wire logic we_n_i, // Write strobe, active low
  input wire logic rst_n_i, // Hardware reset, active low
  input wire logic width_n_i, // High = word
  input wire logic hv_i, // High voltage on protect pin
  input wire logic [DATA_W-1:0] dq_i, // Resolved data bus
  output logic [DATA_W-1:0] dq_q_o, // Data driven by the die
  output logic [DATA_W-1:0] dq_en_o, // Per-bit drive enable
  output logic rb_n_o // Ready (1) or busy (0)
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [logic [ADDR_W:0]];
  logic data_ok = 1'b0;
  logic lb;
  logic wr_act = 1'b0;
  logic prog_go = 1'b0;
  realtime busy_end = 0;
  logic [ADDR_W:0] k_hi, k_lo;
  function automatic logic [7:0] rd(input logic [ADDR_W:0] k);
    rd = mem.exists(k) ? mem[k] : 8'hff;
  endfunction
  assign lb = width_n_i ? 1'b0 : dq_i[15];
  // Array read needs no command and stays valid until a write
  assign dq_q_o = width_n_i ? {rd({addr_i, 1'b1}), rd({addr_i, 1'b0})} : {8'h00, rd({addr_i, lb})};
  assign dq_en_o = (!sel_n_i && !gate_n_i && we_n_i && rst_n_i && data_ok) ?
    (width_n_i ? 16'hffff : 16'h00ff) : 16'h0000;
  // Data only after full access time from select
  always @(negedge sel_n_i) begin
    data_ok = 1'b0;
    #(SEL_NS) data_ok = !sel_n_i;
  end
  always @(posedge sel_n_i) data_ok = 1'b0;
  initial rb_n_o = 1'b1;
  // A write cycle is open while select and strobe are both low
  always @(negedge we_n_i or negedge sel_n_i) wr_act = !we_n_i && !sel_n_i && rst_n_i;
  // Data taken on whichever strobe rises first; both may rise in one time step
  // Top boot sectors only open with high voltage
  always @(posedge we_n_i or posedge sel_n_i) if (wr_act) begin
    wr_act = 1'b0;
    if (hv_i || addr_i[20:16] != 5'h1f) begin
      k_hi = {addr_i, width_n_i ? 1'b1 : lb};
      k_lo = {addr_i, width_n_i ? 1'b0 : lb};
      mem[k_hi] = width_n_i ? dq_i[15:8] : dq_i[7:0];
      mem[k_lo] = dq_i[7:0];
      rb_n_o = 1'b0;
      busy_end = $realtime + PROG_NS;
      prog_go = ~prog_go;
    end
  end
  // Busy timer runs apart from the capture so a write during busy is not missed
  always @(prog_go) begin
    while ($realtime < busy_end) #1;
    if (rst_n_i) rb_n_o = 1'b1;
  end
  // Reset during a program leaves the word unwritten
  always @(negedge rst_n_i) if (rb_n_o === 1'b0 && mem.exists(k_hi)) begin
    mem.delete(k_hi);
    if (mem.exists(k_lo)) mem.delete(k_lo);
  end
  // Busy left low by a program stays low through reset and its recovery
  always @(posedge rst_n_i) begin
    #(REC_NS) rb_n_o = 1'b1;
  end
endmodule

// file: test/test_fbc_ctrl.sv
// Self-checking testbench for the flash bus controller.
module test_fbc_ctrl;
  import fbc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, req_valid_i = 1'b0, word_mode_i = 1'b1, boost_program_i = 1'b0;
  fbc_req_t req_i = '0;
  logic req_ready_o, rsp_valid_o, busy_o, flash_select_n_o, output_gate_n_o, write_strobe_n_o;
  logic flash_reset_n_o, width_select_n_o, protect_boost_hv_o, protect_boost_o, rb_n, tog = 1'b0;
  logic [DATA_W-1:0] rsp_data_o, dq_o, dq_oe_o, dq_bus, m_q, m_en, rdata, s_oe;
  logic [ADDR_W-1:0] flash_addr_o;
  logic [3:0] s_str;
  logic s_w, s_hv;
  int fails = 0, cmp_count = 0, lowcnt;
  // ************
  // Clock, bus resolution, instances
  // ************
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) tog <= ~tog;
  // Undriven bits float to a changing pattern
  assign dq_bus = (dq_oe_o & dq_o) | (~dq_oe_o & m_en & m_q) | (~dq_oe_o & ~m_en & (16'ha5a5 ^ {16{tog}}));
  fbc_ctrl #(.RESET_RECOVERY_CYCLES(20)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i), .word_mode_i(word_mode_i),
    .boost_program_i(boost_program_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .busy_o(busy_o),
    .flash_addr_o(flash_addr_o), .flash_select_n_o(flash_select_n_o), .output_gate_n_o(output_gate_n_o),
    .write_strobe_n_o(write_strobe_n_o), .flash_reset_n_o(flash_reset_n_o), .width_select_n_o(width_select_n_o),
    .protect_boost_hv_o(protect_boost_hv_o), .protect_boost_o(protect_boost_o), .dq_i(dq_bus), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .ready_busy_n_i(rb_n));
  fbc_flash_model flash (.addr_i(flash_addr_o), .sel_n_i(flash_select_n_o), .gate_n_i(output_gate_n_o),
    .we_n_i(write_strobe_n_o), .rst_n_i(flash_reset_n_o), .width_n_i(width_select_n_o),
    .hv_i(protect_boost_hv_o), .dq_i(dq_bus), .dq_q_o(m_q), .dq_en_o(m_en), .rb_n_o(rb_n));
  // ************
  // Shared tasks
  // ************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  // Present a request, snapshot pins mid-access, wait for completion
  task automatic do_req(input fbc_op_t op, input logic [20:0] a, input logic lb, input logic [15:0] d);
    int n;
    n = 0;
    lowcnt = 0;
    req_i.op = op;
    req_i.addr = a;
    req_i.low_byte = lb;
    req_i.wdata = d;
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1 && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    repeat (2) begin
      if (flash_reset_n_o === 1'b0) lowcnt++;
      @(negedge sys_clk_i);
    end
    s_str = {flash_select_n_o, output_gate_n_o, write_strobe_n_o, flash_reset_n_o};
    s_oe = dq_oe_o;
    s_w = width_select_n_o;
    s_hv = protect_boost_hv_o;
    n = 0;
    while (!(op == FBC_OP_READ ? rsp_valid_o === 1'b1 : req_ready_o === 1'b1) && n < 300) begin
      if (flash_reset_n_o === 1'b0) lowcnt++;
      @(negedge sys_clk_i);
      n++;
    end
    if (flash_reset_n_o === 1'b0) lowcnt++;
    if (n >= 300) fails++;
    rdata = rsp_data_o;
  endtask
  // ************
  // Scenarios
  // ************
  task automatic t_idle();
    chk(16'({flash_select_n_o, output_gate_n_o, write_strobe_n_o, flash_reset_n_o}), 16'hf);
    chk(dq_oe_o, 16'h0000);
    chk(16'({width_select_n_o, protect_boost_hv_o, protect_boost_o}), 16'h5);
  endtask
  task automatic t_word();
    do_req(FBC_OP_WRITE, 21'h000123, 1'b0, 16'hbeef);
    chk(16'(s_str), 16'h5);
    chk(s_oe, 16'hffff);
    do_req(FBC_OP_READ, 21'h000123, 1'b0, 16'h0000);
    chk(16'(s_str), 16'h3);
    chk(rdata, 16'hbeef);
    do_req(FBC_OP_READ, 21'h000124, 1'b0, 16'h0000);
    chk(rdata, 16'hffff);
  endtask
  task automatic t_byte();
    word_mode_i = 1'b0;
    do_req(FBC_OP_WRITE, 21'h000040, 1'b1, 16'h003c);
    chk(s_oe, 16'h80ff);
    chk(16'(s_w), 16'h0);
    do_req(FBC_OP_READ, 21'h000040, 1'b1, 16'h0000);
    chk(rdata, 16'h003c);
    do_req(FBC_OP_READ, 21'h000040, 1'b0, 16'h0000);
    chk(rdata, 16'h00ff);
    word_mode_i = 1'b1;
  endtask
  task automatic t_boost();
    do_req(FBC_OP_WRITE, 21'h1f0000, 1'b0, 16'h1234);
    do_req(FBC_OP_READ, 21'h1f0000, 1'b0, 16'h0000);
    chk(rdata, 16'hffff);
    boost_program_i = 1'b1;
    do_req(FBC_OP_WRITE, 21'h1f0000, 1'b0, 16'h1234);
    chk(16'(s_hv), 16'h1);
    boost_program_i = 1'b0;
    do_req(FBC_OP_READ, 21'h1f0000, 1'b0, 16'h0000);
    chk(rdata, 16'h1234);
  endtask
  task automatic t_reset();
    do_req(FBC_OP_WRITE, 21'h000200, 1'b0, 16'h5aa5);
    chk(16'(busy_o), 16'h1);
    do_req(FBC_OP_RESET, 21'h000000, 1'b0, 16'h0000);
    chk(16'(lowcnt), 16'(RESET_PULSE_CYC));
    chk(16'(busy_o), 16'h0);
    do_req(FBC_OP_READ, 21'h000200, 1'b0, 16'h0000);
    chk(rdata, 16'hffff);
    do_req(FBC_OP_WRITE, 21'h000200, 1'b0, 16'h5aa5);
    do_req(FBC_OP_READ, 21'h000200, 1'b0, 16'h0000);
    chk(rdata, 16'h5aa5);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    @(negedge sys_clk_i);
    t_idle();
    t_word();
    t_byte();
    t_boost();
    t_reset();
    end_sim();
  end
  // Whole run needs well under 10 us
  initial begin
    #50000;
    fails++;
    end_sim();
  end
endmodule
